// [pkg/trxcs_cfg.svh]
// Constants of the transceiver control and status register bank.
// Contract
// - Control bit 7 enables AGC lock
// - Control bit 6 forces LNA gain
// - Control bit 5 forces peak tracking
// - Bit 3 starts poll calibration, self-clears
// - Bit 2 starts FSK calibration, self-clears
// - Control bit 1 enables clock output
// - Control bit 0 forces deep sleep
// - Config0 bit 7 selects FSK or ASK
// - Config0 bit 6 forces transmit
// - Config0 bit 5 enables manual gain
// - Config0 bit 4 enables discontinuous receive
// - Config0 bits 3:2 off prescaler
// - Config0 bits 1:0 on prescaler
// - Config1 bit 6 auto FSK calibration
// - Config1 bit 5 continuous clock output
// - Config1 bits 4:3 clock divider select
// - Clock output zero when off, divides 1-8
// - Config1 bits 2:0 dwell exponent code
// - Status bit 7 PLL lock, blocks data
// - Status bit 6 LNA gain state
// - Status bit 5 crystal alive
// - Status read-only, bits 4:2 zero
// - Status bits 1:0 calibration done
// - Done set together with request clear
`ifndef TRXCS_CFG_SVH
`define TRXCS_CFG_SVH
`define TRXCS_IDX_CTRL 8'h01
`define TRXCS_IDX_CONFIGURATION_REGISTER_0 8'h02
`define TRXCS_IDX_CONFIGURATION_REGISTER_1 8'h03
`define TRXCS_IDX_STATUS 8'h1a
`define TRXCS_CTRL_MASK 8'hef
`define TRXCS_CONFIGURATION_REGISTER_0_MASK 8'hff
`define TRXCS_CONFIGURATION_REGISTER_1_MASK 8'h7f
`define TRXCS_RST_BYTE 8'h00
`define TRXCS_B_AGC_LOCK_ENABLE 7
`define TRXCS_B_GAIN 6
`define TRXCS_B_TRK 5
`define TRXCS_B_POLL_TIMER_CAL_START 3
`define TRXCS_B_FSK_CAL_START 2
`define TRXCS_B_XTAL_CLOCK_OUT_ENABLE 1
`define TRXCS_B_SLEEP 0
`define TRXCS_B_MODE 7
`define TRXCS_B_TX 6
`define TRXCS_B_MANUAL_GAIN_ENABLE 5
`define TRXCS_B_DRX 4
`define TRXCS_B_AUTO_FSK_CAL_ENABLE 6
`define TRXCS_B_CONTINUOUS_CLOCK_OUT 5
`define TRXCS_B_LOCK 7
`define TRXCS_B_LNA_GAIN_STATE 6
`define TRXCS_B_ALIVE 5
`define TRXCS_B_POLL_TIMER_CAL_DONE 1
`define TRXCS_B_FSK_CAL_DONE 0
`endif

// [pkg/trxcs_pkg.sv]
// Types of the transceiver control and status register bank.
package trxcs_pkg;
    // Calibration engine state.
    typedef enum logic [1:0] {CAL_IDLE, CAL_BUSY} trxcs_cal_t;
endpackage

// [test/transceiver_ctrl_status_regs_tb_top.sv]
// Self-checking testbench of the transceiver control and status register bank.
`timescale 1ns/1ns
`default_nettype none
`include "trxcs_cfg.svh"
module transceiver_ctrl_status_regs_tb_top;
    // One expected bus result, noted by the driver.
    typedef struct packed {logic wr; logic [7:0] data; logic err;} trxcs_note_t;
    localparam logic [11:0] A_CTRL = {2'b00, `TRXCS_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_CONFIGURATION_REGISTER_0 = {2'b00, `TRXCS_IDX_CONFIGURATION_REGISTER_0, 2'b00};
    localparam logic [11:0] A_CONFIGURATION_REGISTER_1 = {2'b00, `TRXCS_IDX_CONFIGURATION_REGISTER_1, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, `TRXCS_IDX_STATUS, 2'b00};
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic pll_lock_in, lna_high_gain_in, xtal_valid_in, enable_pin, tr_pin;
    logic drx_on_time, drx_wake, poll_cal_finish, fsk_cal_finish;
    logic agc_lock_enable, lna_force_high, manual_gain_enable, peak_track_force;
    logic deep_sleep, fsk_mode, transmit_active, receive_active, drx_en, pclk_out;
    logic poll_cal_run, fsk_cal_run;
    logic [1:0] off_prescale, on_prescale;
    logic [2:0] dwell_code;
    logic [4:0] dwell_exponent;
    logic [7:0] c, c0, c1;
    trxcs_note_t notes[$];
    trxcs_note_t note;
    int n_errors = 0, comparisons = 0, cycles = 0, edges = 0, i, k;
    trxcs_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pll_lock_in(pll_lock_in),
        .lna_high_gain_in(lna_high_gain_in), .xtal_valid_in(xtal_valid_in),
        .enable_pin(enable_pin), .tr_pin(tr_pin), .drx_on_time(drx_on_time),
        .drx_wake(drx_wake), .poll_cal_finish(poll_cal_finish),
        .fsk_cal_finish(fsk_cal_finish), .agc_lock_enable(agc_lock_enable),
        .lna_force_high(lna_force_high), .manual_gain_enable(manual_gain_enable),
        .peak_track_force(peak_track_force), .deep_sleep(deep_sleep), .fsk_mode(fsk_mode),
        .transmit_active(transmit_active), .receive_active(receive_active),
        .discontinuous_receive_enable(drx_en), .off_prescale(off_prescale),
        .on_prescale(on_prescale), .dwell_code(dwell_code),
        .dwell_exponent(dwell_exponent), .poll_cal_run(poll_cal_run),
        .fsk_cal_run(fsk_cal_run), .divided_clock_pin(pclk_out));
    // Pseudo-random source; fixed start keeps every run identical.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected status byte from the live analog inputs and the done flags.
    function automatic logic [7:0] st(input logic pc, input logic fc);
        return {pll_lock_in, lna_high_gain_in, xtal_valid_in, 3'b000, pc, fc};
    endfunction
    // Compares one value and counts the result.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Prints the verdict and stops.
    task automatic end_sim();
        $display("Errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
        input logic [7:0] ed, input logic ee);
        trxcs_note_t n;
        n = '{wr: w, data: ed, err: ee};
        @(posedge pclk);
        notes.push_back(n);
        rnd = lfsr(rnd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {rnd[23:0], d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic ee);
        apb(a, 1'b1, d, 8'h00, ee);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic ee);
        apb(a, 1'b0, 8'h00, ed, ee);
    endtask
    // Checks each field decode except the calibration and clock output bits against the bytes last written.
    task automatic chk_dec(input logic [7:0] c, input logic [7:0] c0, input logic [7:0] c1);
        logic lk;
        lk = pll_lock_in & ~c[0];
        check("agc_lock", c[7], agc_lock_enable);
        check("lna_force", c[6], lna_force_high);
        check("peak_track", c[5], peak_track_force);
        check("sleep", c[0], deep_sleep);
        check("fsk_mode", c0[7], fsk_mode);
        check("tx", lk & (c0[6] | tr_pin), transmit_active);
        check("rx", lk & ~c0[6] & ~tr_pin, receive_active);
        check("manual_gain_enable", c0[5], manual_gain_enable);
        check("drx", c0[4], drx_en);
        check("off_ps", c0[3:2], off_prescale);
        check("on_ps", c0[1:0], on_prescale);
        check("dwell", c1[2:0], dwell_code);
        check("dwell_k", 5'h09 + {1'b0, c1[2:0], 1'b0}, dwell_exponent);
    endtask
    // Counts clock output edges over 64 cycles after a settling gap.
    task automatic clk_meas(input logic [7:0] v1, input logic ck, input logic [31:0] n);
        wr(A_CTRL, {6'h00, ck, 1'b0}, 1'b0);
        wr(A_CONFIGURATION_REGISTER_1, v1, 1'b0);
        repeat (4) @(negedge pclk);
        edges = 0;
        repeat (64) @(negedge pclk);
        check("clk_edges", n, edges);
        if (n == 0) check("clk_pin", 1'b0, pclk_out);
    endtask
    // Bounded wait for the FSK engine to report busy.
    task automatic wait_fsk();
        for (k = 0; k < 4 && fsk_cal_run !== 1'b1; k++) @(negedge pclk);
    endtask
    // Pulses a finish input for one cycle.
    task automatic pulse(input logic p);
        @(posedge pclk);
        if (p) poll_cal_finish <= 1'b1; else fsk_cal_finish <= 1'b1;
        @(posedge pclk);
        poll_cal_finish <= 1'b0;
        fsk_cal_finish <= 1'b0;
        @(negedge pclk);
    endtask
    always @(posedge pclk_out) edges = edges + 1;
    // Free-running clock of 4 ns.
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Watches completed transfers and compares them with the oldest note.
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            n_errors++;
            end_sim();
        end
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            if (notes.size() == 0) check("note_queue", 1'b1, 1'b0);
            else
            begin
                note = notes.pop_front();
                if (!note.wr) check("prdata", {24'h000000, note.data}, prdata);
                check("pslverr", note.err, pslverr);
            end
        end
    end
    // Main sequence.
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, enable_pin, tr_pin} = '0;
        {drx_on_time, drx_wake, poll_cal_finish, fsk_cal_finish, lna_high_gain_in} = '0;
        {clk_en, pll_lock_in, xtal_valid_in} = 3'b111;
        rnd = 32'ha3ff;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_CTRL, 8'h00, 1'b0);
        rd(A_CONFIGURATION_REGISTER_0, 8'h00, 1'b0);
        rd(A_CONFIGURATION_REGISTER_1, 8'h00, 1'b0);
        rd(A_STAT, st(1'b0, 1'b0), 1'b0);
        // Random fields, with the unused bits written as one.
        for (i = 0; i < 12; i++)
        begin
            rnd = lfsr(rnd);
            c = rnd[7:0] & 8'he3;
            c0 = rnd[15:8];
            c1 = rnd[23:16];
            @(posedge pclk);
            {pll_lock_in, tr_pin, lna_high_gain_in, xtal_valid_in} <= rnd[27:24];
            wr(A_CTRL, c | 8'h10, 1'b0);
            wr(A_CONFIGURATION_REGISTER_0, c0, 1'b0);
            wr(A_CONFIGURATION_REGISTER_1, c1 | 8'h80, 1'b0);
            rd(A_CTRL, c, 1'b0);
            rd(A_CONFIGURATION_REGISTER_0, c0, 1'b0);
            rd(A_CONFIGURATION_REGISTER_1, c1 & 8'h7f, 1'b0);
            rd(A_STAT, st(1'b0, 1'b0), 1'b0);
            @(negedge pclk);
            chk_dec(c, c0, c1);
        end
        // Refused accesses leave the control and status registers untouched.
        wr(A_STAT, 8'hff, 1'b1);
        wr(12'h014, 8'hff, 1'b1);
        rd(12'h000, 8'h00, 1'b1);
        rd(12'h005, 8'h00, 1'b1);
        rd(A_CTRL, c, 1'b0);
        rd(A_STAT, st(1'b0, 1'b0), 1'b0);
        // Poll timer calibration, request clears as done sets.
        wr(A_CTRL, 8'h08, 1'b0);
        @(negedge pclk);
        check("poll_run", 1'b1, poll_cal_run);
        rd(A_STAT, st(1'b0, 1'b0), 1'b0);
        pulse(1'b1);
        check("poll_run", 1'b0, poll_cal_run);
        rd(A_CTRL, 8'h00, 1'b0);
        rd(A_STAT, st(1'b1, 1'b0), 1'b0);
        // FSK calibration started by software.
        wr(A_CTRL, 8'h04, 1'b0);
        wait_fsk();
        check("fsk_run", 1'b1, fsk_cal_run);
        pulse(1'b0);
        check("fsk_run", 1'b0, fsk_cal_run);
        rd(A_CTRL, 8'h00, 1'b0);
        rd(A_STAT, st(1'b1, 1'b1), 1'b0);
        // Wake-up calibration only with the automatic enable set.
        wr(A_CONFIGURATION_REGISTER_0, 8'h10, 1'b0);
        wr(A_CONFIGURATION_REGISTER_1, 8'h00, 1'b0);
        drx_wake <= 1'b1;
        repeat (4) @(negedge pclk);
        check("fsk_run", 1'b0, fsk_cal_run);
        @(posedge pclk);
        drx_wake <= 1'b0;
        wr(A_CONFIGURATION_REGISTER_1, 8'h40, 1'b0);
        drx_wake <= 1'b1;
        wait_fsk();
        check("fsk_run", 1'b1, fsk_cal_run);
        rd(A_STAT, st(1'b1, 1'b0), 1'b0);
        pulse(1'b0);
        rd(A_STAT, st(1'b1, 1'b1), 1'b0);
        // Clock output: each divider code, gating and disable.
        wr(A_CONFIGURATION_REGISTER_0, 8'h00, 1'b0);
        for (i = 0; i < 4; i++) clk_meas({3'b001, i[1:0], 3'b000}, 1'b1, 64 >> i);
        clk_meas(8'h08, 1'b1, 0);
        @(posedge pclk);
        enable_pin <= 1'b1;
        clk_meas(8'h08, 1'b1, 32);
        clk_meas(8'h28, 1'b0, 0);
        wr(A_CONFIGURATION_REGISTER_0, 8'h10, 1'b0);
        enable_pin <= 1'b0;
        drx_on_time <= 1'b1;
        clk_meas(8'h10, 1'b1, 16);
        @(posedge pclk);
        drx_on_time <= 1'b0;
        clk_meas(8'h10, 1'b1, 0);
        // A write with the clock enable low must leave the register frozen.
        @(posedge pclk);
        clk_en <= 1'b0;
        wr(A_CONFIGURATION_REGISTER_1, 8'h55, 1'b0);
        @(posedge pclk);
        clk_en <= 1'b1;
        rd(A_CONFIGURATION_REGISTER_1, 8'h10, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire

// [verilog/trxcs_regs.sv]
// Control, configuration and status register bank with APB slave.
`timescale 1ns/1ns
`default_nettype none
`include "trxcs_cfg.svh"
module trxcs_regs
(
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status from the analog side.
    input wire logic pll_lock_in,
    input wire logic lna_high_gain_in,
    input wire logic xtal_valid_in,
    input wire logic enable_pin,
    input wire logic tr_pin,
    input wire logic drx_on_time,
    input wire logic drx_wake,
    input wire logic poll_cal_finish,
    input wire logic fsk_cal_finish,
    // Controls toward the radio.
    output logic agc_lock_enable,
    output logic lna_force_high,
    output logic manual_gain_enable,
    output logic peak_track_force,
    output logic deep_sleep,
    output logic fsk_mode,
    output logic transmit_active,
    output logic receive_active,
    output logic discontinuous_receive_enable,
    output logic [1:0] off_prescale,
    output logic [1:0] on_prescale,
    output logic [2:0] dwell_code,
    output logic [4:0] dwell_exponent,
    output logic poll_cal_run,
    output logic fsk_cal_run,
    output logic divided_clock_pin
);
    // Register storage; unused bits are never stored so they read zero.
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] configuration_register_0_q, configuration_register_0_d;
    logic [7:0] configuration_register_1_q, configuration_register_1_d;
    logic poll_timer_cal_done_q, poll_timer_cal_done_d;
    logic fsk_cal_done_q, fsk_cal_done_d;
    logic [2:0] div_q;
    logic clk_pin_q;
    logic [31:0] prdata_q;
    trxcs_pkg::trxcs_cal_t fsk_cal_start_st_q;
    logic wake_q;

    // Word index from the byte address; printed offsets are indices.
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
    endfunction

    // Bus decode; the slave always answers in the first access cycle.
    wire acc = psel && penable;
    wire wr = acc && pwrite && clk_en;
    wire sel_ctrl = hit(paddr, `TRXCS_IDX_CTRL);
    wire sel_c0 = hit(paddr, `TRXCS_IDX_CONFIGURATION_REGISTER_0);
    wire sel_c1 = hit(paddr, `TRXCS_IDX_CONFIGURATION_REGISTER_1);
    wire sel_st = hit(paddr, `TRXCS_IDX_STATUS);
    wire mapped = sel_ctrl || sel_c0 || sel_c1 || sel_st;
    assign pready = 1'b1;
    // Writes to status are refused with an error as well as ignored.
    assign pslverr = acc && (!mapped || (pwrite && sel_st));

    // Status byte composed from live inputs and done flags.
    wire [7:0] status_w = {pll_lock_in, lna_high_gain_in, xtal_valid_in, 3'h0,
                           poll_timer_cal_done_q, fsk_cal_done_q};
    wire [7:0] rd_byte = sel_ctrl ? ctrl_q : sel_c0 ? configuration_register_0_q :
                         sel_c1 ? configuration_register_1_q : sel_st ? status_w : 8'h00;

    // Auto FSK calibration when leaving sleep in discontinuous mode.
    wire wake_rise = drx_wake && !wake_q;
    wire auto_fsk_cal_start = wake_rise && configuration_register_1_q[`TRXCS_B_AUTO_FSK_CAL_ENABLE] && configuration_register_0_q[`TRXCS_B_DRX];

    // Next control value: write, then hardware clear on finish.
    always_comb
    begin
        ctrl_d = ctrl_q;
        configuration_register_0_d = configuration_register_0_q;
        configuration_register_1_d = configuration_register_1_q;
        poll_timer_cal_done_d = poll_timer_cal_done_q;
        fsk_cal_done_d = fsk_cal_done_q;
        if (wr && sel_ctrl)
        begin
            ctrl_d = pwdata[7:0] & `TRXCS_CTRL_MASK;
        end
        if (wr && sel_c0)
        begin
            configuration_register_0_d = pwdata[7:0] & `TRXCS_CONFIGURATION_REGISTER_0_MASK;
        end
        if (wr && sel_c1)
        begin
            configuration_register_1_d = pwdata[7:0] & `TRXCS_CONFIGURATION_REGISTER_1_MASK;
        end
        // A fresh start drops the old done flag.
        if (ctrl_d[`TRXCS_B_POLL_TIMER_CAL_START] && !ctrl_q[`TRXCS_B_POLL_TIMER_CAL_START])
        begin
            poll_timer_cal_done_d = 1'b0;
        end
        if ((ctrl_d[`TRXCS_B_FSK_CAL_START] && !ctrl_q[`TRXCS_B_FSK_CAL_START]) || auto_fsk_cal_start)
        begin
            fsk_cal_done_d = 1'b0;
        end
        // Finish clears the request and sets done in the same edge.
        if (ctrl_q[`TRXCS_B_POLL_TIMER_CAL_START] && poll_cal_finish)
        begin
            ctrl_d[`TRXCS_B_POLL_TIMER_CAL_START] = 1'b0;
            poll_timer_cal_done_d = 1'b1;
        end
        if (fsk_cal_start_st_q == trxcs_pkg::CAL_BUSY && fsk_cal_finish)
        begin
            ctrl_d[`TRXCS_B_FSK_CAL_START] = 1'b0;
            fsk_cal_done_d = 1'b1;
        end
    end

    // Register update; a write in the finishing cycle loses to the clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `TRXCS_RST_BYTE;
            configuration_register_0_q <= `TRXCS_RST_BYTE;
            configuration_register_1_q <= `TRXCS_RST_BYTE;
            poll_timer_cal_done_q <= 1'b0;
            fsk_cal_done_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else if (clk_en)
        begin
            ctrl_q <= ctrl_d;
            configuration_register_0_q <= configuration_register_0_d;
            configuration_register_1_q <= configuration_register_1_d;
            poll_timer_cal_done_q <= poll_timer_cal_done_d;
            fsk_cal_done_q <= fsk_cal_done_d;
            wake_q <= drx_wake;
        end
    end

    // FSK calibration runs on request bit or automatic wake trigger.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fsk_cal_start_st_q <= trxcs_pkg::CAL_IDLE;
        end
        else if (clk_en)
        begin
            unique case (fsk_cal_start_st_q)
                trxcs_pkg::CAL_IDLE:
                begin
                    if (ctrl_q[`TRXCS_B_FSK_CAL_START] || auto_fsk_cal_start)
                    begin
                        fsk_cal_start_st_q <= trxcs_pkg::CAL_BUSY;
                    end
                end
                trxcs_pkg::CAL_BUSY:
                begin
                    if (fsk_cal_finish)
                    begin
                        fsk_cal_start_st_q <= trxcs_pkg::CAL_IDLE;
                    end
                end
            endcase
        end
    end

    // Read data register, captured in the setup cycle (psel high, penable low).
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0;
        end
        else if (clk_en && psel && !penable && !pwrite)
        begin
            prdata_q <= {24'h0, rd_byte};
        end
    end
    assign prdata = prdata_q;

    // Control decode toward the radio.
    assign agc_lock_enable = ctrl_q[`TRXCS_B_AGC_LOCK_ENABLE];
    assign manual_gain_enable = configuration_register_0_q[`TRXCS_B_MANUAL_GAIN_ENABLE];
    assign lna_force_high = ctrl_q[`TRXCS_B_GAIN];
    assign peak_track_force = ctrl_q[`TRXCS_B_TRK];
    assign deep_sleep = ctrl_q[`TRXCS_B_SLEEP];
    assign fsk_mode = configuration_register_0_q[`TRXCS_B_MODE];
    // Data only moves while the PLL is locked and the chip is awake.
    wire live = pll_lock_in && !deep_sleep;
    assign transmit_active = live && (configuration_register_0_q[`TRXCS_B_TX] || tr_pin);
    assign receive_active = live && !configuration_register_0_q[`TRXCS_B_TX] && !tr_pin;
    assign discontinuous_receive_enable = configuration_register_0_q[`TRXCS_B_DRX];
    assign off_prescale = configuration_register_0_q[3:2];
    assign on_prescale = configuration_register_0_q[1:0];
    assign dwell_code = configuration_register_1_q[2:0];
    assign dwell_exponent = 5'h09 + {1'b0, dwell_code, 1'b0};
    assign poll_cal_run = ctrl_q[`TRXCS_B_POLL_TIMER_CAL_START];
    assign fsk_cal_run = fsk_cal_start_st_q == trxcs_pkg::CAL_BUSY;

    // Clock output gating: continuous, or only in the active window.
    wire ck_window = configuration_register_0_q[`TRXCS_B_DRX] ? drx_on_time : enable_pin;
    wire ck_on = ctrl_q[`TRXCS_B_XTAL_CLOCK_OUT_ENABLE] && (configuration_register_1_q[`TRXCS_B_CONTINUOUS_CLOCK_OUT] || ck_window);
    wire [1:0] cdiv = configuration_register_1_q[4:3];

    // Divider: the pin toggles each clock for /2, each 2 for /4, each 4 for /8.
    // Divide by 1 passes pclk itself through a gate, so it is combinational.
    wire [2:0] div_lim = (cdiv == 2'h2) ? 3'h1 : (cdiv == 2'h3) ? 3'h3 : 3'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= 3'h0;
            clk_pin_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!ck_on || cdiv == 2'h0)
            begin
                div_q <= 3'h0;
                clk_pin_q <= 1'b0;
            end
            else if (div_q >= div_lim)
            begin
                div_q <= 3'h0;
                clk_pin_q <= !clk_pin_q;
            end
            else
            begin
                div_q <= div_q + 3'h1;
            end
        end
    end
    assign divided_clock_pin = (ck_on && cdiv == 2'h0) ? pclk : clk_pin_q;

    // Assertions.
    property p_poll_timer_cal_start_done;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && ctrl_q[`TRXCS_B_POLL_TIMER_CAL_START] && poll_cal_finish) |=> (!ctrl_q[`TRXCS_B_POLL_TIMER_CAL_START] && poll_timer_cal_done_q);
    endproperty
    a_poll_timer_cal_start_done: assert property (p_poll_timer_cal_start_done) else $error("poll cal not retired");

    property p_fsk_cal_start_done;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && fsk_cal_run && fsk_cal_finish) |=> (!ctrl_q[`TRXCS_B_FSK_CAL_START] && fsk_cal_done_q);
    endproperty
    a_fsk_cal_start_done: assert property (p_fsk_cal_start_done) else $error("fsk cal not retired");

    property p_fsk_cal_start_start;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !fsk_cal_run && auto_fsk_cal_start) |=> fsk_cal_run;
    endproperty
    a_fsk_cal_start_start: assert property (p_fsk_cal_start_start) else $error("auto cal missed");

    // Checks the read word itself, since the composed byte is zero there by construction.
    property p_status_rsvd;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && $past(clk_en) && acc && !pwrite && sel_st) |->
            (prdata[31:8] == 24'h0 && prdata[4:2] == 3'h0 && prdata[7] == $past(pll_lock_in));
    endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("status bits wrong");

    property p_st_write;
        @(posedge pclk) disable iff (!presetn)
        (wr && sel_st) |=> $stable(poll_timer_cal_done_q) || poll_cal_finish || $past(poll_cal_finish);
    endproperty
    a_st_write: assert property (p_st_write) else $error("status write took effect");

    property p_ctrl_rsvd;
        @(posedge pclk) disable iff (!presetn)
        ctrl_q[4] == 1'b0 && configuration_register_1_q[7] == 1'b0;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("unused bit stored");

    property p_clk_off;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !ck_on) |=> !clk_pin_q;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock pin not low");

    property p_div8;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && ck_on && cdiv == 2'h3 && $rose(clk_pin_q)) |=>
            (!(clk_en && ck_on && cdiv == 2'h3) || clk_pin_q) [*3];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight broken");

    property p_tx_lock;
        @(posedge pclk) disable iff (!presetn)
        !pll_lock_in |-> !transmit_active && !receive_active;
    endproperty
    a_tx_lock: assert property (p_tx_lock) else $error("data while unlocked");

    c_poll_timer_cal_start: cover property (@(posedge pclk) disable iff (!presetn) $rose(poll_timer_cal_done_q));
    c_fsk_cal_start: cover property (@(posedge pclk) disable iff (!presetn) $rose(fsk_cal_done_q));
    c_auto: cover property (@(posedge pclk) disable iff (!presetn) auto_fsk_cal_start);
    c_clk: cover property (@(posedge pclk) disable iff (!presetn) $rose(clk_pin_q));
endmodule
`default_nettype wire
